// ---- rtl/ppcfg_consts.svh ----
// constants for the port 3 / port 4 pin configuration block
// assumes inclusion by bare name from rtl files
`ifndef PPCFG_CONSTS_SVH
`define PPCFG_CONSTS_SVH

`define PPCFG_ADDR_P3_DRIVE 8'ha7
`define PPCFG_ADDR_P4_DRIVE 8'hae
`define PPCFG_ADDR_P4_DATA 8'hc7
`define PPCFG_ADDR_P3_SKIP 8'hdf
`define PPCFG_ADDR_P4_MODE 8'hf5

`define PPCFG_RST_P3_DRIVE 8'h00
`define PPCFG_RST_P4_DRIVE 8'h00
`define PPCFG_RST_P4_DATA 8'hff
`define PPCFG_RST_P3_SKIP 8'h00
`define PPCFG_RST_P4_MODE 8'hff

`endif

// ---- rtl/ppcfg_pkg.sv ----
// types for the port 3 / port 4 pin configuration block
// assumes nothing of its surroundings
package ppcfg_pkg;

    typedef logic [7:0] ppcfg_byte_t;

    // per-pin controls toward an 8-pin pad ring
    typedef struct packed {
        logic [7:0] out_val;
        logic [7:0] out_en;
        logic [7:0] pullup_en;
        logic [7:0] rx_en;
    } ppcfg_pad_ctl_t;

    // special-function register access
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } ppcfg_sfr_req_t;

endpackage

// ---- rtl/ppcfg_pin_cell.sv ----
// one pad-control slice per pin for an 8-pin port
// assumes mode registers in the clock domain of the caller
`timescale 1ns/100ps
`default_nettype none

module ppcfg_pin_cell (
    input wire logic [7:0] latch_i,
    input wire logic [7:0] push_pull_i,
    input wire logic [7:0] digital_i,
    input wire logic [7:0] periph_en_i,
    input wire logic [7:0] periph_val_i,
    output ppcfg_pkg::ppcfg_pad_ctl_t pad_o
);

    genvar n;
    generate
        for (n = 0; n < 8; n++) begin : g_pin
            wire logic drive_val;
            assign drive_val = periph_en_i[n] ? periph_val_i[n] : latch_i[n];
            assign pad_o.out_val[n] = drive_val;
            // analog pin: driver, pull-up, receiver off
            // open-drain drives only low; push-pull drives both levels
            assign pad_o.out_en[n] = digital_i[n] & (push_pull_i[n] | ~drive_val); // [R1] [R3] [R2] [R4] [R10]
            assign pad_o.pullup_en[n] = digital_i[n] & ~push_pull_i[n]; // [R10]
            assign pad_o.rx_en[n] = digital_i[n]; // [R9] [R10]
        end
    endgenerate

endmodule

`default_nettype wire

// ---- rtl/ppcfg_sync8.sv ----
// two-flop synchroniser for eight pin levels
// assumes asynchronous pin inputs
`timescale 1ns/100ps
`default_nettype none

module ppcfg_sync8 (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic [7:0] async_i,
    output logic [7:0] sync_o
);

    logic [7:0] meta_r;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            meta_r <= 8'h00;
            sync_o <= 8'h00;
        end else begin
            meta_r <= async_i;
            sync_o <= meta_r;
        end
    end

endmodule

`default_nettype wire

// ---- rtl/ppcfg_top.sv ----
// port 3 / port 4 pin configuration and port 4 data logic
// assumes a single-cycle sfr bus on clk_i and pads resolved outside
// What this block does
// [R1] port 3 drive bit: 0 open-drain, 1 push-pull
// [R2] port 3 drive bit ignored for analog pins
// [R3] port 4 drive bit: 0 open-drain, 1 push-pull
// [R4] port 4 drive bit ignored for analog pins
// [R5] port 3 skip bit hides pin from crossbar
// [R6] software should skip analog/special/gpio port 3 pins
// [R7] port 4 data write loads output latches
// [R8] port 4 data read returns pin levels
// [R9] port 4 mode bit: 0 analog, 1 digital
// [R10] analog pin: pull-up, driver, receiver off
// [R11] whole-byte registers, bit n for pin n
`timescale 1ns/100ps
`default_nettype none
`include "ppcfg_consts.svh"

module ppcfg_top (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic sfr_wr_i,
    input wire logic sfr_rd_i,
    output logic [7:0] sfr_rdata_o,
    output logic sfr_hit_o,
    input wire logic [7:0] p3_mode_i,
    input wire logic [7:0] p3_latch_i,
    input wire logic [7:0] p3_periph_en_i,
    input wire logic [7:0] p3_periph_val_i,
    output logic [7:0] p3_skip_o,
    output ppcfg_pkg::ppcfg_pad_ctl_t p3_pad_o,
    input wire logic [7:0] p4_pin_i,
    input wire logic [7:0] p4_periph_en_i,
    input wire logic [7:0] p4_periph_val_i,
    output ppcfg_pkg::ppcfg_pad_ctl_t p4_pad_o,
    output logic [7:0] p4_digital_o
);

    ////////////////////////////////////////////////////////////////////////
    // registers

    ppcfg_pkg::ppcfg_byte_t p3_drive_r;
    ppcfg_pkg::ppcfg_byte_t p4_drive_r;
    ppcfg_pkg::ppcfg_byte_t p4_latch_r;
    ppcfg_pkg::ppcfg_byte_t p3_skip_r;
    ppcfg_pkg::ppcfg_byte_t p4_mode_r;
    logic [7:0] p4_pin_sync;
    logic [7:0] rdata_nxt;

    wire logic hit_p3_drive = (sfr_addr_i == `PPCFG_ADDR_P3_DRIVE);
    wire logic hit_p4_drive = (sfr_addr_i == `PPCFG_ADDR_P4_DRIVE);
    wire logic hit_p4_data = (sfr_addr_i == `PPCFG_ADDR_P4_DATA);
    wire logic hit_p3_skip = (sfr_addr_i == `PPCFG_ADDR_P3_SKIP);
    wire logic hit_p4_mode = (sfr_addr_i == `PPCFG_ADDR_P4_MODE);
    wire logic hit_any = hit_p3_drive | hit_p4_drive | hit_p4_data | hit_p3_skip | hit_p4_mode;

    // whole-byte writes
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            p3_drive_r <= `PPCFG_RST_P3_DRIVE;
            p4_drive_r <= `PPCFG_RST_P4_DRIVE;
            p4_latch_r <= `PPCFG_RST_P4_DATA;
            p3_skip_r <= `PPCFG_RST_P3_SKIP;
            p4_mode_r <= `PPCFG_RST_P4_MODE;
        end else if (sfr_wr_i) begin // [R11]
            if (hit_p3_drive) p3_drive_r <= sfr_wdata_i; // [R1]
            if (hit_p4_drive) p4_drive_r <= sfr_wdata_i; // [R3]
            if (hit_p4_data) p4_latch_r <= sfr_wdata_i; // [R7]
            if (hit_p3_skip) p3_skip_r <= sfr_wdata_i; // [R5]
            if (hit_p4_mode) p4_mode_r <= sfr_wdata_i; // [R9]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin readback

    ppcfg_sync8 u_p4_sync (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .async_i(p4_pin_i),
        .sync_o(p4_pin_sync)
    );

    // analog pins read low: receiver off
    wire logic [7:0] p4_read_val = p4_pin_sync & p4_mode_r; // [R8] [R10]

    assign rdata_nxt = hit_p3_drive ? p3_drive_r :
                       hit_p4_drive ? p4_drive_r :
                       hit_p4_data ? p4_read_val :
                       hit_p3_skip ? p3_skip_r :
                       hit_p4_mode ? p4_mode_r : 8'h00;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sfr_rdata_o <= 8'h00;
            sfr_hit_o <= 1'b0;
        end else begin
            sfr_rdata_o <= sfr_rd_i ? rdata_nxt : 8'h00; // [R11]
            sfr_hit_o <= sfr_rd_i & hit_any;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pad control

    // skipped pins get no crossbar function; software should skip gpio pins
    assign p3_skip_o = p3_skip_r; // [R5] [R6]
    wire logic [7:0] p3_per_en = p3_periph_en_i & ~p3_skip_r; // [R5]
    assign p4_digital_o = p4_mode_r; // [R9]

    ppcfg_pin_cell u_p3_cell (
        .latch_i(p3_latch_i),
        .push_pull_i(p3_drive_r),
        .digital_i(p3_mode_i),
        .periph_en_i(p3_per_en),
        .periph_val_i(p3_periph_val_i),
        .pad_o(p3_pad_o)
    );

    ppcfg_pin_cell u_p4_cell (
        .latch_i(p4_latch_r),
        .push_pull_i(p4_drive_r),
        .digital_i(p4_mode_r),
        .periph_en_i(p4_periph_en_i),
        .periph_val_i(p4_periph_val_i),
        .pad_o(p4_pad_o)
    );

    ////////////////////////////////////////////////////////////////////////
    // checks

    sequence s_p4_latch_wr;
        sfr_wr_i && hit_p4_data;
    endsequence

    sequence s_p3_drive_wr;
        sfr_wr_i && hit_p3_drive;
    endsequence

    sequence s_p4_drive_wr;
        sfr_wr_i && hit_p4_drive;
    endsequence

    sequence s_p3_skip_wr;
        sfr_wr_i && hit_p3_skip;
    endsequence

    sequence s_p4_mode_wr;
        sfr_wr_i && hit_p4_mode;
    endsequence

    sequence s_p4_data_rd;
        sfr_rd_i && hit_p4_data;
    endsequence

    sequence s_mapped_rd;
        sfr_rd_i && hit_any;
    endsequence

    sequence s_unmapped_wr;
        sfr_wr_i && !hit_any;
    endsequence

    AST_P4_LATCH: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R7]
        s_p4_latch_wr |=> p4_latch_r == $past(sfr_wdata_i))
        else $error("port 4 latch not loaded");

    AST_P4_READ: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R8]
        s_p4_data_rd |=> sfr_rdata_o == $past(p4_pin_sync & p4_mode_r))
        else $error("port 4 read not pin level");

    AST_P4_ANALOG: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R10]
        (p4_pad_o.out_en & ~p4_mode_r) == 8'h00 && (p4_pad_o.rx_en == p4_mode_r))
        else $error("analog port 4 pin active");

    AST_P4_PULLUP: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R4]
        (p4_pad_o.pullup_en & ~p4_mode_r) == 8'h00)
        else $error("analog port 4 pull-up on");

    AST_P4_PUSH: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R3]
        (p4_pad_o.out_en & p4_mode_r & p4_drive_r) == (p4_mode_r & p4_drive_r))
        else $error("push-pull pin not driven");

    AST_P3_OPEN: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R1]
        (p3_pad_o.out_en & ~p3_drive_r & p3_pad_o.out_val) == 8'h00)
        else $error("open-drain pin drives high");

    AST_P3_ANALOG: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R2]
        (p3_pad_o.out_en & ~p3_mode_i) == 8'h00)
        else $error("analog port 3 pin driven");

    AST_P3_SKIP: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R5]
        s_p3_skip_wr |=> p3_skip_o == $past(sfr_wdata_i))
        else $error("skip register not loaded");

    AST_MODE_WR: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R9]
        s_p4_mode_wr |=> p4_digital_o == $past(sfr_wdata_i))
        else $error("mode register not loaded");

    AST_UNMAPPED: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R11]
        sfr_rd_i && !hit_any |=> sfr_rdata_o == 8'h00 && !sfr_hit_o)
        else $error("unmapped read not zero");

    AST_P3_DRIVE_WR: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R1]
        s_p3_drive_wr |=> p3_drive_r == $past(sfr_wdata_i))
        else $error("port 3 drive register not loaded");

    AST_P4_DRIVE_WR: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R3]
        s_p4_drive_wr |=> p4_drive_r == $past(sfr_wdata_i))
        else $error("port 4 drive register not loaded");

    AST_P3_DRIVE_RD: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R11]
        sfr_rd_i && hit_p3_drive |=> sfr_rdata_o == $past(p3_drive_r))
        else $error("port 3 drive read wrong");

    AST_P4_DRIVE_RD: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R11]
        sfr_rd_i && hit_p4_drive |=> sfr_rdata_o == $past(p4_drive_r))
        else $error("port 4 drive read wrong");

    AST_P3_SKIP_RD: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R11]
        sfr_rd_i && hit_p3_skip |=> sfr_rdata_o == $past(p3_skip_r))
        else $error("skip read wrong");

    AST_P4_MODE_RD: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R11]
        sfr_rd_i && hit_p4_mode |=> sfr_rdata_o == $past(p4_mode_r))
        else $error("mode read wrong");

    AST_RD_IDLE: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R11]
        !sfr_rd_i |=> sfr_rdata_o == 8'h00 && !sfr_hit_o)
        else $error("read data without read");

    AST_RD_HIT: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R11]
        s_mapped_rd |=> sfr_hit_o)
        else $error("mapped read without hit");

    AST_UNMAPPED_WR: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R11]
        s_unmapped_wr |=> $stable(p3_drive_r) && $stable(p4_drive_r) && $stable(p4_latch_r)
        && $stable(p3_skip_r) && $stable(p4_mode_r))
        else $error("unmapped write changed a register");

    AST_P4_OPEN: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R3]
        (p4_pad_o.out_en & ~p4_drive_r & p4_pad_o.out_val) == 8'h00)
        else $error("port 4 open-drain pin drives high");

    AST_P3_PUSH: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R1]
        (p3_pad_o.out_en & p3_mode_i & p3_drive_r) == (p3_mode_i & p3_drive_r))
        else $error("port 3 push-pull pin not driven");

    AST_P3_ANALOG_PAD: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R2]
        ((p3_pad_o.pullup_en | p3_pad_o.rx_en) & ~p3_mode_i) == 8'h00)
        else $error("analog port 3 pin not idle");

    AST_P4_OD_PULLUP: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R3]
        (p4_pad_o.pullup_en & p4_mode_r & ~p4_drive_r) == (p4_mode_r & ~p4_drive_r))
        else $error("open-drain pull-up off");

    AST_P4_PP_PULLUP: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R3]
        (p4_pad_o.pullup_en & p4_drive_r) == 8'h00)
        else $error("push-pull pull-up on");

    AST_P4_DRIVE_LOW: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R3]
        (p4_pad_o.out_en & p4_mode_r & ~p4_pad_o.out_val) == (p4_mode_r & ~p4_pad_o.out_val))
        else $error("digital low not driven");

    AST_P4_LATCH_OUT: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R7]
        (p4_pad_o.out_val & ~p4_periph_en_i) == (p4_latch_r & ~p4_periph_en_i))
        else $error("port 4 latch not on pad");

    AST_P3_SKIP_OUT: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R5]
        (p3_pad_o.out_val & p3_skip_r) == (p3_latch_i & p3_skip_r))
        else $error("skipped pin took crossbar value");

    AST_P3_XBAR_OUT: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R5]
        (p3_pad_o.out_val & p3_periph_en_i & ~p3_skip_r) ==
        (p3_periph_val_i & p3_periph_en_i & ~p3_skip_r))
        else $error("crossbar value not on pad");

    AST_P4_READ_ANALOG: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R10]
        s_p4_data_rd |=> (sfr_rdata_o & ~$past(p4_mode_r)) == 8'h00)
        else $error("analog pin read not low");

    AST_P4_DATA_HIT: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R8]
        s_p4_data_rd |=> sfr_hit_o)
        else $error("port 4 read without hit");

    AST_P3_DRIVE_HOLD: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R1]
        !(sfr_wr_i && hit_p3_drive) |=> $stable(p3_drive_r))
        else $error("port 3 drive changed without write");

    AST_P4_DRIVE_HOLD: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R3]
        !(sfr_wr_i && hit_p4_drive) |=> $stable(p4_drive_r))
        else $error("port 4 drive changed without write");

    AST_P4_LATCH_HOLD: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R7]
        !(sfr_wr_i && hit_p4_data) |=> $stable(p4_latch_r))
        else $error("port 4 latch changed without write");

    AST_P3_SKIP_HOLD: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R5]
        !(sfr_wr_i && hit_p3_skip) |=> $stable(p3_skip_r))
        else $error("skip changed without write");

    AST_P4_MODE_HOLD: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R9]
        !(sfr_wr_i && hit_p4_mode) |=> $stable(p4_mode_r))
        else $error("mode changed without write");

endmodule

`default_nettype wire

// ---- testbench/ppcfg_pin_model.sv ----
// external circuitry on the port 4 pins: driver, weak pull-up, floating pin
// assumes pad controls from the block and its system clock
`timescale 1ns/100ps
`default_nettype none

module ppcfg_pin_model (
    input wire logic clk_i,
    input wire ppcfg_pkg::ppcfg_pad_ctl_t pad_i,
    input wire logic [7:0] sink_i,
    output logic [7:0] pin_o
);
    logic [7:0] float_r = 8'h55;

    ////////////////////////////////////////////////////////////////////////
    // undriven pin without pull-up wanders every cycle
    always @(posedge clk_i) begin
        float_r <= ~float_r;
    end

    // driven level, else pull-up, else floating; an outside sink pulls low
    assign pin_o = ((pad_i.out_en & pad_i.out_val) | (~pad_i.out_en & pad_i.pullup_en)
        | (~pad_i.out_en & ~pad_i.pullup_en & float_r)) & ~sink_i;
endmodule

`default_nettype wire

// ---- testbench/testbench.sv ----
// self-checking bench for the port 3 / port 4 pin configuration block
// assumes the design files and the pin model compiled first
`timescale 1ns/100ps
`default_nettype none
`include "ppcfg_consts.svh"

module testbench;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] mode3 = 8'hff;
    logic [7:0] latch3 = 8'h00;
    logic [7:0] pen3 = 8'h00;
    logic [7:0] pval3 = 8'h00;
    logic [7:0] pen4 = 8'h00;
    logic [7:0] pval4 = 8'h00;
    logic [7:0] sink4 = 8'h00;
    wire logic [7:0] rdata;
    wire logic [7:0] skip3;
    wire logic [7:0] pins4;
    wire logic [7:0] dig4;
    wire logic hit;
    wire ppcfg_pkg::ppcfg_pad_ctl_t pad3;
    wire ppcfg_pkg::ppcfg_pad_ctl_t pad4;
    int n_errors = 0;
    int compares = 0;

    ////////////////////////////////////////////////////////////////////////
    ppcfg_top u_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .sfr_addr_i(addr),
        .sfr_wdata_i(wdata), .sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_rdata_o(rdata),
        .sfr_hit_o(hit), .p3_mode_i(mode3), .p3_latch_i(latch3), .p3_periph_en_i(pen3),
        .p3_periph_val_i(pval3), .p3_skip_o(skip3), .p3_pad_o(pad3), .p4_pin_i(pins4),
        .p4_periph_en_i(pen4), .p4_periph_val_i(pval4), .p4_pad_o(pad4), .p4_digital_o(dig4));
    ppcfg_pin_model u_pins (.clk_i(clk_i), .pad_i(pad4), .sink_i(sink4), .pin_o(pins4));

    initial begin
        forever #25 clk_i = ~clk_i;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(posedge clk_i);
        #1;
        wr = 1'b0;
        @(posedge clk_i);
        #1;
    endtask

    task automatic sfr_rd(input logic [7:0] a, input logic [7:0] exp, input logic exp_hit);
        addr = a;
        rd = 1'b1;
        @(posedge clk_i);
        #1;
        rd = 1'b0;
        check("read data", exp, rdata);
        check("read hit", {7'h00, exp_hit}, {7'h00, hit});
        @(posedge clk_i);
        #1;
        check("read data idle", 8'h00, rdata);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic test_reset();
        sfr_wr(8'h00, 8'h5a);
        sfr_rd(`PPCFG_ADDR_P3_DRIVE, 8'h00, 1'b1);
        sfr_rd(`PPCFG_ADDR_P4_DRIVE, 8'h00, 1'b1);
        sfr_rd(`PPCFG_ADDR_P3_SKIP, 8'h00, 1'b1);
        sfr_rd(`PPCFG_ADDR_P4_MODE, 8'hff, 1'b1);
        sfr_rd(`PPCFG_ADDR_P4_DATA, 8'hff, 1'b1);
        sfr_rd(8'h00, 8'h00, 1'b0);
    endtask

    task automatic test_port4_digital();
        sfr_wr(`PPCFG_ADDR_P4_DATA, 8'h5a);
        sink4 = 8'h0f;
        repeat (3) @(posedge clk_i);
        #1;
        check("p4 open-drain enable", 8'ha5, pad4.out_en);
        check("p4 open-drain pull-up", 8'hff, pad4.pullup_en);
        sfr_rd(`PPCFG_ADDR_P4_DATA, 8'h50, 1'b1);
        sink4 = 8'h00;
        sfr_wr(`PPCFG_ADDR_P4_DRIVE, 8'hff);
        check("p4 push-pull enable", 8'hff, pad4.out_en);
        check("p4 push-pull pull-up", 8'h00, pad4.pullup_en);
        check("p4 output value", 8'h5a, pad4.out_val);
        sfr_rd(`PPCFG_ADDR_P4_DRIVE, 8'hff, 1'b1);
    endtask

    task automatic test_port4_analog();
        sfr_wr(`PPCFG_ADDR_P4_DRIVE, 8'h00);
        sfr_wr(`PPCFG_ADDR_P4_MODE, 8'h0f);
        check("p4 digital flags", 8'h0f, dig4);
        check("p4 analog enable", 8'h05, pad4.out_en);
        check("p4 analog pull-up", 8'h0f, pad4.pullup_en);
        check("p4 analog receiver", 8'h0f, pad4.rx_en);
        repeat (3) @(posedge clk_i);
        #1;
        sfr_rd(`PPCFG_ADDR_P4_DATA, 8'h0a, 1'b1);
        sfr_wr(`PPCFG_ADDR_P4_DRIVE, 8'hff);
        check("p4 analog ignores drive", 8'h0f, pad4.out_en);
    endtask

    task automatic test_port3();
        mode3 = 8'hf0;
        pen3 = 8'hff;
        pval3 = 8'hff;
        sfr_wr(`PPCFG_ADDR_P3_DRIVE, 8'h3c);
        sfr_wr(`PPCFG_ADDR_P3_SKIP, 8'h0f);
        check("p3 skip flags", 8'h0f, skip3);
        check("p3 analog ignores drive", 8'h30, pad3.out_en);
        check("p3 pull-up", 8'hc0, pad3.pullup_en);
        check("p3 analog receiver", 8'hf0, pad3.rx_en);
        mode3 = 8'hff;
        @(posedge clk_i);
        #1;
        check("p3 skipped enable", 8'h3f, pad3.out_en);
        check("p3 skipped pull-up", 8'hc3, pad3.pullup_en);
        check("p3 skipped value", 8'hf0, pad3.out_val);
        sfr_rd(`PPCFG_ADDR_P3_SKIP, 8'h0f, 1'b1);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        #1000000;
        n_errors++;
        finish_test();
    end

    initial begin
        repeat (12) @(posedge clk_i);
        #1;
        reset_n_i = 1'b1;
        test_reset();
        test_port4_digital();
        test_port4_analog();
        test_port3();
        finish_test();
    end
endmodule

`default_nettype wire
